// ### hdl/can_wake_pkg.sv
// constants for the can wake and fail-safe control block
package can_wake_pkg;

  // register offsets
  localparam logic [7:0] ADDR_CTRL      = 8'h20;
  localparam logic [7:0] ADDR_STATUS    = 8'h22;
  localparam logic [7:0] ADDR_WAKE_STAT = 8'h4B;

  // field positions
  localparam int CTRL_MODE_LSB   = 0;
  localparam int STAT_ACTIVE     = 7;
  localparam int STAT_SILENCE    = 3;
  localparam int STAT_UNDER      = 1;
  localparam int STAT_TXTIMEOUT  = 0;
  localparam int WAKE_LEVEL      = 1;

  // reset values
  localparam logic [1:0] CTRL_MODE_RESET = 2'h0;
  localparam logic [7:0] REG_ZERO        = 8'h00;

  // sbc mode code meaning normal
  localparam logic [2:0] SBC_NORMAL = 3'h7;

  // transceiver mode select encodings
  localparam logic [1:0] SEL_OFFLINE   = 2'h0;
  localparam logic [1:0] SEL_ACTIVE_UV = 2'h1;
  localparam logic [1:0] SEL_ACTIVE    = 2'h2;
  localparam logic [1:0] SEL_LISTEN    = 2'h3;

  // transceiver states, one-hot
  typedef enum logic [3:0] {
    XCV_OFFLINE = 4'h1,
    XCV_BIAS    = 4'h2,
    XCV_ACTIVE  = 4'h4,
    XCV_LISTEN  = 4'h8
  } xcv_state_t;

  // wake filter phases, one-hot
  typedef enum logic [2:0] {
    WK_DOM1 = 3'h1,
    WK_REC  = 3'h2,
    WK_DOM2 = 3'h4
  } wake_phase_t;

  // clock rate
  localparam int CLK_MHZ = 250;

  // times in microseconds (plain defaults)
  localparam int T_DOM_TXD_US = 2000;
  localparam int T_SILENCE_US = 1000;
  localparam int T_WAKE_US    = 1000;
  localparam int T_WAKE_DOM_US = 1;
  localparam int T_WAKE_REC_US = 1;
  localparam int T_EVENT_US   = 300;

  // cycle counts derived from the times
  localparam int CYC_DOM_TXD  = T_DOM_TXD_US * CLK_MHZ;
  localparam int CYC_SILENCE  = T_SILENCE_US * CLK_MHZ;
  localparam int CYC_WAKE     = T_WAKE_US * CLK_MHZ;
  localparam int CYC_WAKE_DOM = T_WAKE_DOM_US * CLK_MHZ;
  localparam int CYC_WAKE_REC = T_WAKE_REC_US * CLK_MHZ;
  localparam int CYC_EVENT    = T_EVENT_US * CLK_MHZ;

  // counter width for all timers
  localparam int CNT_W = 24;

endpackage

// ### hdl/pin_sync3.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
module pin_sync3 #(
  parameter int         W    = 1,
  parameter logic [W-1:0] INIT = '0
) (
  // clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_reset,
  // asynchronous pins in, clean levels out
  input  wire logic [W-1:0] i_pin,
  output logic      [W-1:0] o_level
);

  //////////////////////////////////////////////////////////////////////////
  logic [W-1:0] s1_q;     // metastable stage, read only by s2
  logic [W-1:0] s2_q;     // second stage
  logic [W-1:0] s3_q;     // third stage
  logic [W-1:0] lvl_q;    // accepted level
  logic [W-1:0] lvl_d;

  // per bit: accept a change once stages two and three agree
  genvar g;
  generate
    for (g = 0; g < W; g++)
    begin : g_bit
      always_comb
      begin
        lvl_d[g] = (s2_q[g] == s3_q[g]) ? s3_q[g] : lvl_q[g];
      end
    end
  endgenerate

  // plain register stage
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      s1_q  <= INIT;
      s2_q  <= INIT;
      s3_q  <= INIT;
      lvl_q <= INIT;
    end
    else
    begin
      s1_q  <= i_pin;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      lvl_q <= lvl_d;
    end
  end

  assign o_level = lvl_q;

endmodule

// ### hdl/can_wake_failsafe_ctrl.sv
// can transceiver mode, bus wake filter and fail-safe control
`timescale 1ns/10ps
module can_wake_failsafe_ctrl #(
  parameter int TXD_DOM_CYC  = can_wake_pkg::CYC_DOM_TXD,
  parameter int SILENCE_CYC  = can_wake_pkg::CYC_SILENCE,
  parameter int WAKE_TO_CYC  = can_wake_pkg::CYC_WAKE,
  parameter int WAKE_DOM_CYC = can_wake_pkg::CYC_WAKE_DOM,
  parameter int WAKE_REC_CYC = can_wake_pkg::CYC_WAKE_REC,
  parameter int EVENT_CYC    = can_wake_pkg::CYC_EVENT
) (
  // clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_reset,
  // register port
  input  wire logic [7:0] i_reg_addr,
  input  wire logic       i_reg_wr,
  input  wire logic [7:0] i_reg_wdata,
  output logic      [7:0] o_reg_rdata,
  // sbc context
  input  wire logic [2:0] i_sbc_mode_field,
  input  wire logic       i_supply_under,
  input  wire logic       i_sleep_req,
  output logic            o_sleep_allowed,
  output logic            o_sleeping,
  output logic            o_main_supply_on,
  output logic            o_wake_reset,
  // capture enables, loaded together
  input  wire logic       i_enable_load,
  input  wire logic       i_bus_wake_enable,
  input  wire logic       i_can_fail_enable,
  input  wire logic       i_pin_rise_wake_enable,
  input  wire logic       i_pin_fall_wake_enable,
  // event flags and write-one-to-clear strobes
  input  wire logic [3:0] i_event_clear,
  output logic [3:0]      o_event_flags,
  // pins
  input  wire logic       i_bus_rx,
  input  wire logic       i_tx_input_pin,
  input  wire logic       i_wake_pin,
  output logic            o_tx_bus,
  output logic            o_rx_output_pin
);

  //////////////////////////////////////////////////////////////////////////
  // synchronised pins
  logic       bus_rx;           // 0 = dominant
  logic       tx_in;            // 0 = dominant request
  logic       wake_lvl;         // wake pin above threshold
  logic       bus_prev_q;       // edge detection of bus
  logic       wake_prev_q;      // edge detection of wake pin

  pin_sync3 #(
    .W    (3),
    .INIT (3'h3)
  ) u_sync (
    .i_clk   (i_clk),
    .i_reset (i_reset),
    .i_pin   ({i_wake_pin, i_tx_input_pin, i_bus_rx}),
    .o_level ({wake_lvl, tx_in, bus_rx})
  );

  //////////////////////////////////////////////////////////////////////////
  // registers and enables
  logic [1:0] mode_sel_q;       // transceiver_mode_select
  logic [1:0] mode_sel_d;
  logic [3:0] en_q;             // wake, fail, rise, fall enables
  logic [3:0] en_d;
  logic       is_normal;

  assign is_normal = (i_sbc_mode_field == can_wake_pkg::SBC_NORMAL);

  // next values of control and enables
  always_comb
  begin
    mode_sel_d = mode_sel_q;
    en_d       = en_q;
    // only the mode bits take a write
    if (i_reg_wr && i_reg_addr == can_wake_pkg::ADDR_CTRL)
    begin
      mode_sel_d = i_reg_wdata[can_wake_pkg::CTRL_MODE_LSB +: 2];
    end
    if (i_enable_load)
    begin
      en_d = {i_pin_fall_wake_enable, i_pin_rise_wake_enable,
              i_can_fail_enable, i_bus_wake_enable};
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      mode_sel_q <= can_wake_pkg::CTRL_MODE_RESET;
      en_q       <= 4'h0;
    end
    else
    begin
      mode_sel_q <= mode_sel_d;
      en_q       <= en_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // bus silence and tx dominant timers
  localparam int W = can_wake_pkg::CNT_W;
  logic [W-1:0] sil_cnt_q;      // cycles since last bus edge
  logic [W-1:0] sil_cnt_d;
  logic [W-1:0] dom_cnt_q;      // cycles tx held dominant
  logic [W-1:0] dom_cnt_d;
  logic         tx_to_q;        // tx_timeout_status
  logic         tx_to_d;
  logic         bus_edge;
  logic         silent;
  can_wake_pkg::xcv_state_t st_q;
  can_wake_pkg::xcv_state_t st_d;

  assign bus_edge = (bus_rx != bus_prev_q);
  // silence once no edge for the timeout
  assign silent   = (sil_cnt_q >= W'(SILENCE_CYC));

  // timer next values
  always_comb
  begin
    sil_cnt_d = sil_cnt_q;
    dom_cnt_d = '0;
    tx_to_d   = tx_to_q;
    if (bus_edge)
    begin
      sil_cnt_d = '0;
    end
    else if (!silent)
    begin
      sil_cnt_d = sil_cnt_q + W'(1);
    end
    // count while tx low in active mode
    if (st_q == can_wake_pkg::XCV_ACTIVE && !tx_in && !tx_to_q)
    begin
      dom_cnt_d = dom_cnt_q + W'(1);
      if (dom_cnt_q >= W'(TXD_DOM_CYC))
      begin
        tx_to_d = 1'b1;
      end
    end
    // status drops once tx is released again
    if (tx_to_q && tx_in)
    begin
      tx_to_d = 1'b0;
    end
  end

  // timer registers; silence starts expired so bus starts offline
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      sil_cnt_q   <= W'(SILENCE_CYC);
      dom_cnt_q   <= '0;
      tx_to_q     <= 1'b0;
      bus_prev_q  <= 1'b1;
      wake_prev_q <= 1'b0;  // pin idles low, no false edge
    end
    else
    begin
      sil_cnt_q   <= sil_cnt_d;
      dom_cnt_q   <= dom_cnt_d;
      tx_to_q     <= tx_to_d;
      bus_prev_q  <= bus_rx;
      wake_prev_q <= wake_lvl;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // transceiver mode machine
  logic uv_on;                  // undervoltage detection selected
  logic bus_wake;               // pulse from wake filter

  assign uv_on = (mode_sel_q == can_wake_pkg::SEL_ACTIVE_UV);

  // next transceiver state
  always_comb
  begin
    st_d = st_q;
    case (st_q)
      can_wake_pkg::XCV_OFFLINE:
      begin
        if (bus_wake || (is_normal && uv_on && i_supply_under))
          st_d = can_wake_pkg::XCV_BIAS;
      end
      can_wake_pkg::XCV_BIAS:
      begin
        // silence takes bias back to offline
        if (silent)
          st_d = can_wake_pkg::XCV_OFFLINE;
      end
      default:
      begin
        st_d = silent ? can_wake_pkg::XCV_OFFLINE : can_wake_pkg::XCV_BIAS;
      end
    endcase
    // selection obeyed only in normal mode
    if (is_normal)
    begin
      case (mode_sel_q)
        can_wake_pkg::SEL_ACTIVE_UV, can_wake_pkg::SEL_ACTIVE:
        begin
          if (uv_on && i_supply_under)
          begin
            if (st_q == can_wake_pkg::XCV_ACTIVE ||
                st_q == can_wake_pkg::XCV_LISTEN)
              st_d = silent ? can_wake_pkg::XCV_OFFLINE
                            : can_wake_pkg::XCV_BIAS;
          end
          else if (tx_to_q)
            st_d = can_wake_pkg::XCV_LISTEN;
          // a dominant tx blocks entry into active
          else if (st_q != can_wake_pkg::XCV_ACTIVE && !tx_in)
            st_d = can_wake_pkg::XCV_LISTEN;
          else
            st_d = can_wake_pkg::XCV_ACTIVE;
        end
        can_wake_pkg::SEL_LISTEN:
        begin
          st_d = can_wake_pkg::XCV_LISTEN;
        end
        default:
        begin
        end
      endcase
    end
  end

  // transceiver state register
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
      st_q <= can_wake_pkg::XCV_OFFLINE;
    else
      st_q <= st_d;
  end

  //////////////////////////////////////////////////////////////////////////
  // bus wake filter
  can_wake_pkg::wake_phase_t ph_q;
  can_wake_pkg::wake_phase_t ph_d;
  logic [W-1:0] run_q;          // length of current bus level
  logic [W-1:0] run_d;
  logic [W-1:0] wto_q;          // time since first dominant qualified
  logic [W-1:0] wto_d;
  logic         watching;

  // only offline with bus wake enabled
  assign watching = (st_q == can_wake_pkg::XCV_OFFLINE) && en_q[0];

  // next filter values; extra short pulses only restart the run
  always_comb
  begin
    ph_d     = ph_q;
    run_d    = bus_edge ? W'(0) : run_q + W'(1);
    wto_d    = (ph_q == can_wake_pkg::WK_DOM1) ? W'(0) : wto_q + W'(1);
    bus_wake = 1'b0;
    if (!watching)
    begin
      ph_d  = can_wake_pkg::WK_DOM1;
      wto_d = '0;
    end
    // pattern after the first dominant inside the wake timeout
    else if (ph_q != can_wake_pkg::WK_DOM1 && wto_q >= W'(WAKE_TO_CYC))
    begin
      ph_d = can_wake_pkg::WK_DOM1;
    end
    else
    begin
      case (ph_q)
        can_wake_pkg::WK_DOM1:
        begin
          // edge cycle still holds the old run length, so skip it
          if (!bus_edge && !bus_rx && run_q + W'(1) >= W'(WAKE_DOM_CYC))
            ph_d = can_wake_pkg::WK_REC;
        end
        can_wake_pkg::WK_REC:
        begin
          if (!bus_edge && bus_rx && run_q + W'(1) >= W'(WAKE_REC_CYC))
            ph_d = can_wake_pkg::WK_DOM2;
        end
        can_wake_pkg::WK_DOM2:
        begin
          if (!bus_edge && !bus_rx && run_q + W'(1) >= W'(WAKE_DOM_CYC))
          begin
            bus_wake = 1'b1;
            ph_d     = can_wake_pkg::WK_DOM1;
          end
        end
        default:
        begin
          ph_d = can_wake_pkg::WK_DOM1;
        end
      endcase
    end
  end

  // filter registers
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      ph_q  <= can_wake_pkg::WK_DOM1;
      run_q <= '0;
      wto_q <= '0;
    end
    else
    begin
      ph_q  <= ph_d;
      run_q <= run_d;
      wto_q <= wto_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // events, delay timer, sleep and supply
  logic [3:0]   ev_q;           // wake, fail, rise, fall
  logic [3:0]   ev_d;
  logic [3:0]   ev_set;
  logic [W-1:0] dly_q;          // event delay, nonzero while running
  logic [W-1:0] dly_d;
  logic         sleep_q;
  logic         sleep_d;
  logic         wrst_q;
  logic         wrst_d;
  logic         uv_prev_q;
  logic         uv_rise;

  assign uv_rise = i_supply_under && !uv_prev_q && uv_on;

  // next event and power values
  always_comb
  begin
    ev_set[0] = bus_wake;
    ev_set[1] = en_q[1] && ((tx_to_d && !tx_to_q) || uv_rise);
    ev_set[2] = en_q[2] && wake_lvl && !wake_prev_q;
    ev_set[3] = en_q[3] && !wake_lvl && wake_prev_q;
    // write one clears, set wins over clear
    ev_d  = (ev_q & ~i_event_clear) | ev_set;
    dly_d = (dly_q != '0) ? dly_q - W'(1) : W'(0);
    // clearing a set flag restarts delay
    if ((i_event_clear & ev_q) != 4'h0)
      dly_d = W'(EVENT_CYC);
    sleep_d = sleep_q;
    wrst_d  = 1'b0;
    // sleep only with a wake source
    if (i_sleep_req && o_sleep_allowed)
      sleep_d = 1'b1;
    // wake from sleep restores supply via reset
    if (sleep_q && (ev_set[0] || ev_set[2] || ev_set[3]))
    begin
      sleep_d = 1'b0;
      wrst_d  = 1'b1;
    end
  end

  // event registers
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      ev_q      <= 4'h0;
      dly_q     <= '0;
      sleep_q   <= 1'b0;
      wrst_q    <= 1'b0;
      uv_prev_q <= 1'b0;
    end
    else
    begin
      ev_q      <= ev_d;
      dly_q     <= dly_d;
      sleep_q   <= sleep_d;
      wrst_q    <= wrst_d;
      uv_prev_q <= i_supply_under;
    end
  end

  assign o_sleep_allowed  = en_q[0] | en_q[2] | en_q[3];
  assign o_sleeping       = sleep_q;
  assign o_main_supply_on = !sleep_q;
  assign o_wake_reset     = wrst_q;
  assign o_event_flags    = ev_q;

  //////////////////////////////////////////////////////////////////////////
  // pin outputs and register read
  logic tx_bus_q;
  logic rx_q;
  logic rx_d;
  logic offline;

  assign offline = (st_q == can_wake_pkg::XCV_OFFLINE) ||
                   (st_q == can_wake_pkg::XCV_BIAS);

  // pending events pull rx low in offline while awake
  always_comb
  begin
    if (offline && !sleep_q)
      // next values, so a clear releases rx on its own edge
      rx_d = !((ev_d != 4'h0) && (dly_d == '0));
    else
      rx_d = bus_rx;
  end

  // output flops; transmitter released unless active
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      tx_bus_q <= 1'b1;
      rx_q     <= 1'b1;
    end
    else
    begin
      tx_bus_q <= (st_d == can_wake_pkg::XCV_ACTIVE) ? tx_in : 1'b1;
      rx_q     <= rx_d;
    end
  end

  assign o_tx_bus        = tx_bus_q;
  assign o_rx_output_pin = rx_q;

  // combinational read mux, unmapped reads zero
  always_comb
  begin
    o_reg_rdata = can_wake_pkg::REG_ZERO;
    case (i_reg_addr)
      can_wake_pkg::ADDR_CTRL:
      begin
        o_reg_rdata[can_wake_pkg::CTRL_MODE_LSB +: 2] = mode_sel_q;
      end
      can_wake_pkg::ADDR_STATUS:
      begin
        // active flag
        // timeout hides active before the state has left it
        o_reg_rdata[can_wake_pkg::STAT_ACTIVE] =
          (st_q == can_wake_pkg::XCV_ACTIVE) && !tx_to_q;
        o_reg_rdata[can_wake_pkg::STAT_SILENCE] = silent;
        // undervoltage shown only with mode 01
        o_reg_rdata[can_wake_pkg::STAT_UNDER] = uv_on && i_supply_under;
        o_reg_rdata[can_wake_pkg::STAT_TXTIMEOUT] = tx_to_q;
      end
      can_wake_pkg::ADDR_WAKE_STAT:
      begin
        // level valid in normal or enabled
        o_reg_rdata[can_wake_pkg::WAKE_LEVEL] =
          wake_lvl && (is_normal || en_q[2] || en_q[3]);
      end
      default:
      begin
      end
    endcase
  end

endmodule

// ### bench/can_wake_monitor.sv
// concurrent checks on the can wake and fail-safe control ports
`timescale 1ns/10ps
module can_wake_monitor #(
  parameter int TXD_DOM_CYC = 100
) (
  // clock and reset
  input wire logic       i_clk,
  input wire logic       i_reset,
  // inputs under watch
  input wire logic [7:0] i_reg_addr,
  input wire logic [2:0] i_sbc_mode_field,
  input wire logic [3:0] i_event_clear,
  // outputs under watch
  input wire logic [7:0] o_reg_rdata,
  input wire logic [3:0] o_event_flags,
  input wire logic       o_tx_bus,
  input wire logic       o_rx_output_pin,
  input wire logic       o_sleeping,
  input wire logic       o_sleep_allowed,
  input wire logic       o_main_supply_on,
  input wire logic       o_wake_reset
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);

  ////////////////////////////////////////////////////////////////////////////
  // length of the current dominant drive on the transmitter
  logic [15:0] dom_q;
  logic [15:0] dom_d;
  // counter returns to zero on a recessive transmitter or at 16'hFFFF, far above the bound, so no wrap hides a fault
  always_comb
    dom_d = (o_tx_bus || dom_q == 16'hFFFF) ? 16'h0000 : dom_q + 16'h0001;
  always_ff @(posedge i_clk) dom_q <= i_reset ? 16'h0000 : dom_d;

  ////////////////////////////////////////////////////////////////////////////
  a_reset_quiet: assert property (disable iff (1'b0) i_reset |=>
    (o_tx_bus && o_rx_output_pin && o_event_flags == 4'h0 && !o_sleeping))
    else $error("outputs not at rest after reset");
  a_dom_bounded: assert property (dom_q <= TXD_DOM_CYC + 8)
    else $error("transmitter held dominant too long");
  a_timeout_inactive: assert property (
    (i_reg_addr == can_wake_pkg::ADDR_STATUS && o_reg_rdata[0]) |->
    !o_reg_rdata[7]) else $error("active flag with tx timeout");
  a_active_normal: assert property (
    (i_reg_addr == can_wake_pkg::ADDR_STATUS && o_reg_rdata[7]) |->
    $past(i_sbc_mode_field) == can_wake_pkg::SBC_NORMAL)
    else $error("active outside normal mode");
  a_reserved_zero: assert property (
    (i_reg_addr == can_wake_pkg::ADDR_STATUS ||
     i_reg_addr == can_wake_pkg::ADDR_WAKE_STAT) |-> (o_reg_rdata &
    (i_reg_addr == can_wake_pkg::ADDR_STATUS ? 8'h74 : 8'hFD)) == 8'h00)
    else $error("reserved bit reads one");
  a_unmapped_zero: assert property ((i_reg_addr != can_wake_pkg::ADDR_CTRL &&
    i_reg_addr != can_wake_pkg::ADDR_STATUS &&
    i_reg_addr != can_wake_pkg::ADDR_WAKE_STAT) |-> o_reg_rdata == 8'h00)
    else $error("unmapped address reads nonzero");
  a_flags_sticky: assert property ((($past(o_event_flags) &
    ~o_event_flags & ~$past(i_event_clear)) == 4'h0))
    else $error("event flag fell without clear");
  a_clear_release: assert property (
    (|(o_event_flags & i_event_clear)) |=> o_rx_output_pin [*4])
    else $error("rx not released after clear");
  a_supply_sleep: assert property (o_main_supply_on == !o_sleeping)
    else $error("supply does not follow sleep");
  a_sleep_source: assert property ($rose(o_sleeping) |->
    $past(o_sleep_allowed)) else $error("sleep entered with no wake source");
  a_wake_pulse: assert property (o_wake_reset |=> !o_wake_reset)
    else $error("wake reset pulse too long");

  // main scenarios reached
  c_bus_wake: cover property ($rose(o_event_flags[0]));
  c_wake_reset: cover property (o_wake_reset);
  c_tx_timeout: cover property (i_reg_addr == 8'h22 && o_reg_rdata[0]);
endmodule

bind can_wake_failsafe_ctrl can_wake_monitor #(.TXD_DOM_CYC(TXD_DOM_CYC))
  i_can_wake_monitor (.i_clk, .i_reset, .i_reg_addr, .i_sbc_mode_field,
  .i_event_clear, .o_reg_rdata, .o_event_flags, .o_tx_bus, .o_rx_output_pin,
  .o_sleeping, .o_sleep_allowed, .o_main_supply_on, .o_wake_reset);

// ### bench/can_ctrl_model.sv
// controller-side model: drives the transmit pin low for a set span
`timescale 1ns/10ps
module can_ctrl_model (
  // clock
  input  wire logic        i_clk,
  // command from the bench
  input  wire logic        i_go,
  input  wire logic [15:0] i_len,
  // transmit pin, 1 recessive
  output logic             o_tx
);
  logic [15:0] left_q = 16'h0000; // dominant cycles still to send
  initial o_tx = 1'b1;
  // bounded dominant stretch
  // command taken on the rising edge, where the bench holds it stable
  always @(posedge i_clk)
  begin
    if (i_go) left_q <= i_len;
    else if (left_q != 16'h0000) left_q <= left_q - 16'h0001;
  end
  // pin moves on the falling edge, away from the sampling edge
  always @(negedge i_clk) o_tx <= (left_q == 16'h0000);
endmodule

// ### bench/testbench.sv
// self-checking bench for the can wake and fail-safe control block
`timescale 1ns/10ps
module testbench;
  localparam int TXD = 100; // shortened timer spans
  localparam int SIL = 150;
  localparam int WTO = 200;
  localparam int EVT = 60;
  logic i_clk, i_reset, i_reg_wr, i_supply_under, i_sleep_req, i_enable_load;
  logic i_bus_wake_enable, i_can_fail_enable, i_bus_rx, i_wake_pin, go;
  logic i_pin_rise_wake_enable, i_pin_fall_wake_enable, wake_seen;
  logic [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata;
  logic [2:0] i_sbc_mode_field;
  logic [3:0] i_event_clear, o_event_flags;
  logic [15:0] len;
  logic tx_pin, o_sleep_allowed, o_sleeping, o_main_supply_on, o_wake_reset;
  logic o_tx_bus, o_rx_output_pin;
  int err_total = 0;
  int num_checks = 0;

  can_wake_failsafe_ctrl #(.TXD_DOM_CYC(TXD), .SILENCE_CYC(SIL),
    .WAKE_TO_CYC(WTO), .WAKE_DOM_CYC(6), .WAKE_REC_CYC(6), .EVENT_CYC(EVT))
    i_can_wake_failsafe_ctrl (.i_clk, .i_reset, .i_reg_addr, .i_reg_wr,
    .i_reg_wdata, .o_reg_rdata, .i_sbc_mode_field, .i_supply_under,
    .i_sleep_req, .o_sleep_allowed, .o_sleeping, .o_main_supply_on,
    .o_wake_reset, .i_enable_load, .i_bus_wake_enable, .i_can_fail_enable,
    .i_pin_rise_wake_enable, .i_pin_fall_wake_enable, .i_event_clear,
    .o_event_flags, .i_bus_rx, .i_tx_input_pin(tx_pin), .i_wake_pin,
    .o_tx_bus, .o_rx_output_pin);
  can_ctrl_model i_can_ctrl_model (.i_clk, .i_go(go), .i_len(len),
    .o_tx(tx_pin));

  ////////////////////////////////////////////////////////////////////////////
  // clock, and a latch for the one-cycle wake reset pulse
  initial
  begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end
  always @(posedge i_clk) if (o_wake_reset === 1'b1) wake_seen <= 1'b1;

  ////////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(string nm, logic [7:0] exp, logic [7:0] got);
    num_checks++;
    if (got !== exp)
    begin
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
      err_total++;
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(negedge i_clk);
  endtask
  // one-cycle write strobe; address and data left standing
  task automatic wr(logic [7:0] a, logic [7:0] d);
    i_reg_addr = a;
    i_reg_wdata = d;
    i_reg_wr = 1'b1;
    cyc(1);
    i_reg_wr = 1'b0;
  endtask
  // read data is combinational, looked at mid-cycle
  task automatic rd(logic [7:0] a, logic [7:0] exp, string nm);
    i_reg_addr = a;
    #0.5 chk(nm, exp, o_reg_rdata);
    cyc(1);
  endtask
  task automatic en(logic [3:0] e);
    {i_bus_wake_enable, i_can_fail_enable} = e[3:2];
    {i_pin_rise_wake_enable, i_pin_fall_wake_enable} = e[1:0];
    i_enable_load = 1'b1;
    cyc(1);
    i_enable_load = 1'b0;
  endtask
  task automatic clr(logic [3:0] m);
    i_event_clear = m;
    cyc(1);
    i_event_clear = 4'h0;
  endtask
  task automatic bus(logic lvl, int n);
    i_bus_rx = lvl;
    cyc(n);
  endtask
  task automatic send(int n);
    len = 16'(n);
    go = 1'b1;
    cyc(1);
    go = 1'b0;
  endtask
  task automatic flags(logic [3:0] e, string nm);
    chk(nm, {4'h0, e}, {4'h0, o_event_flags});
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    rd(can_wake_pkg::ADDR_CTRL, 8'h00, "ctrl reset");
    rd(can_wake_pkg::ADDR_STATUS, 8'h08, "status reset");
    wr(can_wake_pkg::ADDR_CTRL, 8'hFF);
    rd(can_wake_pkg::ADDR_CTRL, 8'h03, "ctrl reserved");
    wr(can_wake_pkg::ADDR_STATUS, 8'hFF);
    cyc(4);
    rd(can_wake_pkg::ADDR_STATUS, 8'h08, "mode outside normal");
    rd(8'h55, 8'h00, "unmapped");
    i_sbc_mode_field = can_wake_pkg::SBC_NORMAL;
    for (int m = 0; m < 4; m++)
    begin
      wr(can_wake_pkg::ADDR_CTRL, 8'(m));
      cyc(4);
      rd(can_wake_pkg::ADDR_STATUS, (m == 1 || m == 2) ? 8'h88 : 8'h08,
        "mode decode");
    end
  endtask
  task automatic t_txd();
    wr(can_wake_pkg::ADDR_CTRL, {6'h00, can_wake_pkg::SEL_ACTIVE});
    cyc(4);
    send(20);
    cyc(10);
    chk("tx passes", 8'h00, {7'h00, o_tx_bus});
    cyc(20);
    send(TXD + 30);
    cyc(TXD + 15);
    rd(can_wake_pkg::ADDR_STATUS, 8'h09, "timeout status");
    chk("tx released", 8'h01, {7'h00, o_tx_bus});
    flags(4'h0, "capture off");
    cyc(30);
    rd(can_wake_pkg::ADDR_STATUS, 8'h88, "timeout gone");
    en(4'h4);
    send(TXD + 30);
    cyc(TXD + 45);
    flags(4'h2, "fail event");
    clr(4'hD);
    flags(4'h2, "other clears");
    cyc(1);
    clr(4'h2);
    flags(4'h0, "fail cleared");
  endtask
  task automatic t_under();
    wr(can_wake_pkg::ADDR_CTRL, {6'h00, can_wake_pkg::SEL_ACTIVE_UV});
    cyc(4);
    i_supply_under = 1'b1;
    cyc(6);
    rd(can_wake_pkg::ADDR_STATUS, 8'h0A, "under status");
    flags(4'h2, "under event");
    wr(can_wake_pkg::ADDR_CTRL, {6'h00, can_wake_pkg::SEL_ACTIVE});
    cyc(4);
    rd(can_wake_pkg::ADDR_STATUS, 8'h88, "under ignored");
    i_supply_under = 1'b0;
    clr(4'h2);
  endtask
  task automatic t_bus_wake();
    i_sbc_mode_field = 3'h4;
    wr(can_wake_pkg::ADDR_CTRL, 8'h00);
    en(4'hE);
    bus(1'b1, SIL + 10);
    bus(1'b0, 2);
    bus(1'b1, 2);
    bus(1'b0, 2);
    bus(1'b1, 8);
    flags(4'h0, "short phases");
    rd(can_wake_pkg::ADDR_STATUS, 8'h00, "bus busy");
    bus(1'b1, SIL + 10);
    rd(can_wake_pkg::ADDR_STATUS, 8'h08, "bus silent");
    bus(1'b0, 10);
    bus(1'b1, WTO + 20);
    bus(1'b0, 10);
    bus(1'b1, WTO + 20);
    flags(4'h0, "late pattern");
    bus(1'b0, 10);
    bus(1'b1, 3);
    bus(1'b0, 3);
    bus(1'b1, 10);
    bus(1'b0, 10);
    bus(1'b1, 8);
    flags(4'h1, "bus wake");
    chk("rx alert", 8'h00, {7'h00, o_rx_output_pin});
    i_wake_pin = 1'b1;
    cyc(6);
    flags(4'h5, "pin rise");
    rd(can_wake_pkg::ADDR_WAKE_STAT, 8'h02, "pin high");
    clr(4'h1);
    cyc(2);
    chk("rx released", 8'h01, {7'h00, o_rx_output_pin});
    cyc(EVT + 4);
    chk("rx re-alert", 8'h00, {7'h00, o_rx_output_pin});
    i_wake_pin = 1'b0;
    clr(4'h4);
    cyc(EVT + 6);
    chk("rx idle", 8'h01, {7'h00, o_rx_output_pin});
    flags(4'h0, "fall disabled");
    rd(can_wake_pkg::ADDR_WAKE_STAT, 8'h00, "pin low");
  endtask
  task automatic t_sleep();
    en(4'h0);
    chk("no source", 8'h00, {7'h00, o_sleep_allowed});
    i_sleep_req = 1'b1;
    cyc(3);
    i_sleep_req = 1'b0;
    chk("sleep refused", 8'h00, {7'h00, o_sleeping});
    en(4'h8);
    i_sleep_req = 1'b1;
    cyc(3);
    i_sleep_req = 1'b0;
    chk("asleep", 8'h01, {7'h00, o_sleeping});
    bus(1'b1, SIL + 10);
    bus(1'b0, 10);
    bus(1'b1, 10);
    bus(1'b0, 10);
    bus(1'b1, 12);
    chk("awake", 8'h01, {7'h00, o_main_supply_on});
    chk("wake reset", 8'h01, {7'h00, wake_seen});
    flags(4'h1, "sleep wake");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // main sequence; inputs move only on falling edges
  initial
  begin
    {i_reg_wr, i_supply_under, i_sleep_req, i_enable_load, go} = 5'h00;
    {i_bus_wake_enable, i_can_fail_enable} = 2'h0;
    {i_pin_rise_wake_enable, i_pin_fall_wake_enable} = 2'h0;
    {i_reg_addr, i_reg_wdata, i_event_clear, len} = 36'h0;
    // wake pin grounded, local wake off
    {i_bus_rx, i_wake_pin, wake_seen} = 3'h4;
    i_sbc_mode_field = 3'h0;
    i_reset = 1'b1;
    cyc(6);
    i_reset = 1'b0;
    t_regs();
    t_txd();
    t_under();
    t_bus_wake();
    t_sleep();
    conclude();
  end
  // hang guard, well past the some 1600 cycles the tests need
  initial
  begin
    #100000;
    err_total++;
    conclude();
  end
endmodule
